/* File: logic/ppr_pkg.sv */
package ppr_pkg;
  // sample and setting widths
  localparam int W = 16;                        // signed 16-bit process values
  localparam int AW = 32;                       // accumulator width
  localparam int REG_AW = 4;                    // register address width
  localparam logic signed [W-1:0] VMAX = 16'sh7fff;
  localparam logic signed [W-1:0] VMIN = -16'sh7fff;
  localparam logic signed [AW-1:0] AMAX = 32'sh00007fff;
  localparam logic signed [AW-1:0] AMIN = -32'sh00007fff;
  // gain fixed point: q8.8 proportional gain
  localparam int KP_FRAC = 8;
  localparam int TI_FRAC = 4;                   // integral scale shift
  localparam int TD_FRAC = 4;                   // derivative scale shift
  localparam int FILT_FRAC = 8;                 // filter accumulator fraction bits
  // current loop 4~20 mA: 4 mA sits at a fifth of full scale
  localparam logic [W-1:0] CUR_ZERO = 16'h1999;
  localparam logic [W-1:0] CUR_SPAN_NUM = 16'h5000; // 5/4 in q.14
  localparam int CUR_SHIFT = 14;
  localparam logic signed [W-1:0] RAW_MAX = 16'sh7fff;
  // control period
  localparam real PERIOD_US = 100.0;
  localparam real CLK_MHZ = 250.0;
  localparam int PERIOD_CYC = int'(PERIOD_US * CLK_MHZ);
  localparam logic [15:0] PERIOD_LAST = 16'(PERIOD_CYC - 1);
  // settings encodings
  localparam logic [7:0] REF_SRC_OPER = 8'h00;
  localparam logic [7:0] REF_SRC_AUX = 8'h01;
  localparam logic [7:0] REF_SRC_NET = 8'h02;
  localparam logic [7:0] AUX_FUNC_TARGET = 8'h09;
  // register indexes
  localparam logic [REG_AW-1:0] A_CTRL = 4'h0;  // [0]enable [1]trim [2]fb sel
  localparam logic [REG_AW-1:0] A_KP = 4'h1;
  localparam logic [REG_AW-1:0] A_TI = 4'h2;
  localparam logic [REG_AW-1:0] A_TD = 4'h3;
  localparam logic [REG_AW-1:0] A_BIAS = 4'h4;
  localparam logic [REG_AW-1:0] A_LIMA = 4'h5;
  localparam logic [REG_AW-1:0] A_LIMB = 4'h6;
  localparam logic [REG_AW-1:0] A_ILIM = 4'h7;
  localparam logic [REG_AW-1:0] A_FILT = 4'h8;
  localparam logic [REG_AW-1:0] A_SRC = 4'h9;   // [7:0] ref src, [15:8] aux func
  localparam logic [REG_AW-1:0] A_OPREF = 4'ha;
  localparam logic [REG_AW-1:0] A_STAT = 4'hb;
  localparam logic [REG_AW-1:0] A_OUT = 4'hc;
  localparam int B_EN = 0;
  localparam int B_TRIM = 1;
  localparam int B_FB = 2;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] KP_RST = 16'h0100;    // gain one
  localparam logic [15:0] LIM_RST = 16'h7fff;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] bias;
    logic [15:0] lim_a;
    logic [15:0] lim_b;
    logic [15:0] ilim;
    logic [15:0] filt;
    logic [15:0] src;
    logic [15:0] opref;
  } ppr_cfg_s;

  typedef struct packed {
    ppr_cfg_s               cfg;
    logic [15:0]            tick;
    logic signed [W-1:0]    err_prev;
    logic signed [AW-1:0]   integ;
    logic signed [AW-1:0]   filt_acc;
    logic signed [W-1:0]    pid_out;
    logic                   at_limit;
    logic signed [W-1:0]    freq_ref;
    logic [15:0]            rdata;
  } ppr_state_s;
endpackage : ppr_pkg

/* File: logic/ppr_regulator.sv */
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - run only when enable set; else bypass
// - error is target minus feedback
// - result replaces or trims frequency reference
// - proportional term is error times gain
// - integral time zero disables integral term
// - derivative time zero disables derivative term
// - integrator clamped to integral limit both signs
// - output saturates at limit both signs; in trim mode freq_ref adds speed_ref after the limit and is not clamped to it
// - integrator holds while output at limit
// - fixed bias added to output
// - first order filter smooths the output
// - feedback from voltage or current input
// - target from keypad, network or aux
// - aux target needs source 01, function 09
module ppr_regulator
  import ppr_pkg::*;
(
  input  wire logic                 mclk,          // 250 MHz clock
  input  wire logic                 rst_b,         // sync reset, active low
  input  wire logic [REG_AW-1:0]    addr,          // register index
  input  wire logic [15:0]          wdata,         // write data
  input  wire logic                 wr,            // write strobe
  input  wire logic                 rd,            // read strobe
  output logic      [15:0]          rdata,         // read data, cycle after rd
  input  wire logic signed [W-1:0]  voltage_feedback_input, // 0~10 V scaled
  input  wire logic signed [W-1:0]  current_feedback_input, // 4~20 mA scaled
  input  wire logic signed [W-1:0]  net_target,    // target from network port
  input  wire logic signed [W-1:0]  aux_target,    // aux analog input
  input  wire logic signed [W-1:0]  speed_ref,     // existing speed reference
  output logic signed [W-1:0]       freq_ref       // frequency reference out
);

  ppr_state_s q;
  ppr_state_s next_q;

  // saturate a wide value to the 16-bit range
  function automatic logic signed [W-1:0] sat16(input logic signed [AW-1:0] v);
    if (v > AMAX) begin
      sat16 = VMAX;
    end else if (v < AMIN) begin
      sat16 = VMIN;
    end else begin
      sat16 = v[W-1:0];
    end
  endfunction : sat16

  // symmetric clamp by a positive magnitude
  function automatic logic signed [AW-1:0] clamp(input logic signed [AW-1:0] v,
                                                 input logic [15:0] m);
    logic signed [AW-1:0] pm;
    pm = AW'($signed({1'b0, m[14:0]}));
    if (v > pm) begin
      clamp = pm;
    end else if (v < -pm) begin
      clamp = -pm;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  logic                  tick_hit;
  logic                  aux_sel;
  logic signed [W-1:0]   fb;
  logic signed [W-1:0]   target;
  logic signed [W-1:0]   err;
  logic signed [AW-1:0]  cur_wide;
  logic signed [AW-1:0]  p_term;
  logic signed [AW-1:0]  i_step;
  logic signed [AW-1:0]  i_next;
  logic signed [AW-1:0]  d_term;
  logic signed [AW-1:0]  sum;
  logic signed [AW-1:0]  lim_sum;
  logic [15:0]           lim;
  logic signed [AW-1:0]  filt_step;
  logic signed [AW-1:0]  filt_acc_next;
  logic signed [W-1:0]   filt_out;
  logic signed [AW-1:0]  trimmed;

  // datapath for one control update
  always_comb begin
    tick_hit = (q.tick == PERIOD_LAST);
    // current input: remove the 4 mA floor and stretch 16 mA to full span
    cur_wide = ((AW'(current_feedback_input) - AW'($signed({1'b0, CUR_ZERO})))
                * AW'($signed({1'b0, CUR_SPAN_NUM}))) >>> CUR_SHIFT;
    fb = q.cfg.ctrl[B_FB] ? sat16(cur_wide) : voltage_feedback_input;
    aux_sel = (q.cfg.src[7:0] == REF_SRC_AUX)
              && (q.cfg.src[15:8] == AUX_FUNC_TARGET);
    if (aux_sel) begin
      target = aux_target;
    end else if (q.cfg.src[7:0] == REF_SRC_NET) begin
      target = net_target;
    end else begin
      target = $signed(q.cfg.opref);
    end
    err = sat16(AW'(target) - AW'(fb));
    p_term = (AW'(err) * AW'($signed({1'b0, q.cfg.kp}))) >>> KP_FRAC;
    // a shorter integral time takes a bigger step each period
    if (q.cfg.ti == 16'h0000) begin
      i_step = '0;
    end else begin
      i_step = (AW'(err) <<< TI_FRAC) / AW'($signed({1'b0, q.cfg.ti}));
    end
    if (q.cfg.ti == 16'h0000) begin
      i_next = '0;
    end else if (q.at_limit) begin
      i_next = q.integ;
    end else begin
      i_next = clamp(q.integ + i_step, q.cfg.ilim);
    end
    if (q.cfg.td == 16'h0000) begin
      d_term = '0;
    end else begin
      // error step saturated first so the product cannot overflow the accumulator
      d_term = (AW'(sat16(AW'(err) - AW'(q.err_prev))) * AW'($signed({1'b0, q.cfg.td})))
               >>> TD_FRAC;
    end
    sum = AW'(sat16(p_term)) + q.integ + AW'(sat16(d_term))
          + AW'($signed(q.cfg.bias));
    // the tighter of the two limit settings wins
    lim = (q.cfg.lim_a[14:0] < q.cfg.lim_b[14:0]) ? q.cfg.lim_a : q.cfg.lim_b;
    lim_sum = clamp(sat16(sum), lim);
    // filter: larger time constant means smaller correction per period
    // fraction bits keep small steps from being lost to truncation
    filt_step = ((lim_sum <<< FILT_FRAC) - q.filt_acc)
                / (AW'($signed({1'b0, q.cfg.filt})) + 1);
    filt_acc_next = q.filt_acc + filt_step;
    filt_out = sat16(filt_acc_next >>> FILT_FRAC);
    trimmed = q.cfg.ctrl[B_TRIM] ? AW'(speed_ref) + AW'(q.pid_out)
                                 : AW'(q.pid_out);

    next_q = q;
    next_q.tick = tick_hit ? '0 : q.tick + 16'h0001;
    if (wr) begin
      unique case (addr)
        A_CTRL: next_q.cfg.ctrl = wdata;
        A_KP: next_q.cfg.kp = wdata;
        A_TI: next_q.cfg.ti = wdata;
        A_TD: next_q.cfg.td = wdata;
        A_BIAS: next_q.cfg.bias = wdata;
        A_LIMA: next_q.cfg.lim_a = wdata;
        A_LIMB: next_q.cfg.lim_b = wdata;
        A_ILIM: next_q.cfg.ilim = wdata;
        A_FILT: next_q.cfg.filt = wdata;
        A_SRC: next_q.cfg.src = wdata;
        A_OPREF: next_q.cfg.opref = wdata;
        default: ;
      endcase
    end
    next_q.rdata = '0;
    if (rd) begin
      unique case (addr)
        A_CTRL: next_q.rdata = q.cfg.ctrl;
        A_KP: next_q.rdata = q.cfg.kp;
        A_TI: next_q.rdata = q.cfg.ti;
        A_TD: next_q.rdata = q.cfg.td;
        A_BIAS: next_q.rdata = q.cfg.bias;
        A_LIMA: next_q.rdata = q.cfg.lim_a;
        A_LIMB: next_q.rdata = q.cfg.lim_b;
        A_ILIM: next_q.rdata = q.cfg.ilim;
        A_FILT: next_q.rdata = q.cfg.filt;
        A_SRC: next_q.rdata = q.cfg.src;
        A_OPREF: next_q.rdata = q.cfg.opref;
        A_STAT: next_q.rdata = {15'h0000, q.at_limit};
        A_OUT: next_q.rdata = q.pid_out;
        default: next_q.rdata = '0;                  // unmapped reads zero
      endcase
    end
    // regulator state clears while disabled and only moves on the period tick while enabled
    if (!q.cfg.ctrl[B_EN]) begin
      next_q.integ = '0;
      next_q.err_prev = '0;
      next_q.filt_acc = '0;
      next_q.pid_out = '0;
      next_q.at_limit = 1'b0;
      next_q.freq_ref = speed_ref;
    end else begin
      if (tick_hit) begin
        next_q.integ = i_next;
        next_q.err_prev = err;
        next_q.filt_acc = filt_acc_next;
        next_q.pid_out = filt_out;
        next_q.at_limit = (lim_sum != sat16(sum));
      end
      next_q.freq_ref = sat16(trimmed);
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
      q.cfg.ctrl <= CTRL_RST;
      q.cfg.kp <= KP_RST;
      q.cfg.lim_a <= LIM_RST;
      q.cfg.lim_b <= LIM_RST;
      q.cfg.ilim <= LIM_RST;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign freq_ref = q.freq_ref;

endmodule : ppr_regulator
`default_nettype wire

/* File: tb/ppr_regulator_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module ppr_regulator_checker
  import ppr_pkg::*;
(
  input wire logic                 mclk,      // clock
  input wire logic                 rst_b,     // sync reset, active low
  input wire logic [REG_AW-1:0]    addr,      // register index
  input wire logic [15:0]          wdata,     // write data
  input wire logic                 wr,        // write strobe
  input wire logic                 rd,        // read strobe
  input wire logic [15:0]          rdata,     // read data
  input wire logic signed [W-1:0]  speed_ref, // existing speed reference
  input wire logic signed [W-1:0]  freq_ref   // frequency reference out
);
  logic [15:0]         sh [0:10];
  logic [15:0]         exp_rd;
  logic signed [W-1:0] lim;
  logic                en;
  logic                trim;
  // the lower of the two output limits is in force; their top bit is ignored
  always_comb begin
    lim = (sh[5][14:0] < sh[6][14:0]) ? $signed({1'b0, sh[5][14:0]})
                                       : $signed({1'b0, sh[6][14:0]});
  end
  assign en = sh[0][B_EN];
  assign trim = sh[0][B_TRIM];
  // shadow copy; read-only and unmapped indexes never take a write
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      foreach (sh[i]) sh[i] <= (i == 1) ? KP_RST : (i inside {5, 6, 7}) ? LIM_RST : 16'h0000;
    end else if (wr && addr <= A_OPREF) begin
      sh[addr] <= wdata;
    end
    exp_rd <= (addr <= A_OPREF) ? sh[addr] : 16'h0000;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_rd_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (rd && addr > A_OUT |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_reg_readback: assert property (rd && addr <= A_OPREF |=> rdata == exp_rd)
    else $error("setting read back differs");
  a_reset_clear: assert property ($rose(rst_b) |-> rdata == 16'h0000 && freq_ref == 16'sh0000)
    else $error("outputs not cleared by reset");
  a_bypass_speed: assert property (!en && $past(en) == 1'b0 && $past(rst_b) |->
    freq_ref == $past(speed_ref)) else $error("disabled output not speed reference");
  a_lim_high: assert property (en && $past(en) && !trim && $changed(freq_ref) |->
    freq_ref <= lim) else $error("output above limit");
  a_lim_low: assert property (en && $past(en) && !trim && $changed(freq_ref) |->
    freq_ref >= -lim) else $error("output below negative limit");
  a_period_hold: assert property (en && !trim && $past(en, 9) && $changed(freq_ref) |=>
    $stable(freq_ref) [*8]) else $error("output updated off the control period");
endmodule : ppr_regulator_checker
bind ppr_regulator ppr_regulator_checker u_chk (.mclk(mclk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .speed_ref(speed_ref), .freq_ref(freq_ref));
`default_nettype wire

/* File: tb/ppr_sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ppr_sensor_model
  import ppr_pkg::*;
(
  input  wire logic               mclk,                   // clock
  input  wire logic signed [W-1:0] volt_level,            // voltage sensor, 0..7fff
  input  wire logic signed [W-1:0] loop_level,            // current-loop sensor, 0..7fff
  input  wire logic signed [W-1:0] speed_level,           // speed source
  output logic signed [W-1:0]     voltage_feedback_input, // 0~10 V scaled
  output logic signed [W-1:0]     current_feedback_input, // 4~20 mA scaled
  output logic signed [W-1:0]     speed_ref               // speed reference
);
  // live zero of 4 mA plus four fifths of span; exact only for multiples of five
  always_ff @(posedge mclk) begin
    voltage_feedback_input <= volt_level;
    current_feedback_input <= CUR_ZERO + 16'((32'(loop_level) * 4) / 5);
    speed_ref <= speed_level;
  end
endmodule : ppr_sensor_model
`default_nettype wire

/* File: tb/test_ppr_regulator.sv */
`timescale 1ns/10ps
`default_nettype none
module test_ppr_regulator
  import ppr_pkg::*;
;
  logic                mclk = 1'b0;
  logic                rst_b = 1'b0;
  logic [REG_AW-1:0]   addr = '0;
  logic [15:0]         wdata = '0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic signed [W-1:0] volt = '0, loop_l = '0, spd = '0, net_t = '0, aux_t = '0;
  logic signed [W-1:0] vfb, cfb, sref, freq_ref;
  logic [15:0]         rdata;
  int                  miscompares = 0;
  int                  n_checks = 0;
  always #2 mclk = ~mclk;
  ppr_sensor_model u_sens (.mclk(mclk), .volt_level(volt), .loop_level(loop_l),
    .speed_level(spd), .voltage_feedback_input(vfb), .current_feedback_input(cfb),
    .speed_ref(sref));
  ppr_regulator u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .voltage_feedback_input(vfb), .current_feedback_input(cfb),
    .net_target(net_t), .aux_target(aux_t), .speed_ref(sref), .freq_ref(freq_ref));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // bus cycles: one-cycle strobes launched just after an edge
  task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [REG_AW-1:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  // one control period plus margin; a miss ends the run
  task automatic wait_out(input logic [15:0] e);
    int i;
    for (i = 0; i < PERIOD_CYC + 16 && freq_ref !== e; i++) @(negedge mclk);
    chk(freq_ref, e);
    if (i >= PERIOD_CYC + 16) wrap_up();
  endtask : wait_out
  // reset values, readback, a read-only and an unmapped index
  task automatic t_regs;
    rd_chk(A_KP, KP_RST);
    rd_chk(A_LIMA, LIM_RST);
    rd_chk(A_ILIM, LIM_RST);
    rd_chk(A_CTRL, CTRL_RST);
    wr_reg(A_TI, 16'h0003);
    rd_chk(A_TI, 16'h0003);
    wr_reg(A_TI, 16'h0000);
    wr_reg(A_STAT, 16'hffff);
    rd_chk(A_STAT, 16'h0000);
    rd_chk(4'hf, 16'h0000);
  endtask : t_regs
  task automatic t_bypass;
    @(posedge mclk);
    spd <= 16'sh1234;
    repeat (3) @(posedge mclk);
    #1 chk(freq_ref, 16'h1234);
  endtask : t_bypass
  // network target, voltage feedback, unity gain, replace mode
  task automatic t_net;
    @(posedge mclk);
    net_t <= 16'sh1000;
    volt <= 16'sh0400;
    wr_reg(A_SRC, {8'h00, REF_SRC_NET});
    wr_reg(A_CTRL, 16'h0001);
    wait_out(16'h0c00);
  endtask : t_net
  // keypad target against the current loop; derivative pulls 0x700 down by 0x500
  task automatic t_loop;
    @(posedge mclk);
    loop_l <= 16'sh0500;
    wr_reg(A_OPREF, 16'h0c00);
    wr_reg(A_SRC, {8'h00, REF_SRC_OPER});
    wr_reg(A_TI, 16'h0010);
    wr_reg(A_TD, 16'h0010);
    wr_reg(A_BIAS, 16'h0100);
    wr_reg(A_ILIM, 16'h0200);
    wr_reg(A_CTRL, 16'h0005);
    wait_out(16'h0300);
  endtask : t_loop
  // aux target drives the output into its negative limit
  task automatic t_aux;
    @(posedge mclk);
    aux_t <= -16'sh2000;
    wr_reg(A_LIMB, 16'h0800);
    wr_reg(A_SRC, {AUX_FUNC_TARGET, REF_SRC_AUX});
    wr_reg(A_CTRL, 16'h0001);
    wait_out(16'hf800);
    rd_chk(A_STAT, 16'h0001);
  endtask : t_aux
  // trim mode: zero error, integrator clamped at -0x200, bias 0x100, filter halves the step
  task automatic t_trim;
    wr_reg(A_TD, 16'h0000);
    wr_reg(A_OPREF, 16'h0400);
    wr_reg(A_SRC, {8'h00, REF_SRC_OPER});
    wr_reg(A_FILT, 16'h0001);
    wr_reg(A_CTRL, 16'h0003);
    wait_out(16'h0db4);
    rd_chk(A_OUT, 16'hfb80);
    rd_chk(A_STAT, 16'h0000);
  endtask : t_trim
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_bypass();
    t_net();
    t_loop();
    t_aux();
    t_trim();
    wrap_up();
  end
endmodule : test_ppr_regulator
`default_nettype wire
